// *** srw_core_model.sv ***
// processor core model issuing sleep, kick and wake events
`timescale 1ns/1ps
module srw_core_model (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // requests from the bench
  input wire req_sleep,
  input wire req_kick,
  input wire req_wake,
  // core state
  input wire cpu_clk_run_reg,
  input wire sleeping_reg,
  // core events
  output reg sleep_instr,
  output reg kick_instr,
  output reg wake_event
);
  // instructions only run on a clocked core; wake is a held level
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sleep_instr <= 1'b0;
      kick_instr  <= 1'b0;
      wake_event  <= 1'b0;
    end else begin
      sleep_instr <= req_sleep & cpu_clk_run_reg;
      kick_instr  <= req_kick & cpu_clk_run_reg;
      wake_event  <= req_wake | (wake_event & sleeping_reg);
    end
  end
endmodule

// *** srw_map.vh ***
// register map, field positions, reset values and timing constants
`ifndef SRW_MAP_VH
`define SRW_MAP_VH

// ========
// register byte addresses
`define SRW_ADDR_SLEEP     8'h00
`define SRW_ADDR_GATE      8'h04
`define SRW_ADDR_WDOG      8'h08
`define SRW_ADDR_FLAGS     8'h0C
`define SRW_ADDR_STATUS    8'h10

// ========
// sleep_power_control fields
`define SRW_SLP_ALLOW      5
`define SRW_SLP_KIND_HI    4
`define SRW_SLP_KIND_LO    3
`define SRW_SLP_RSVD       2
`define SRW_SLP_RESET      8'h00
`define SRW_SLP_RMASK      8'hFB

// sleep kinds
`define SRW_KIND_IDLE      2'h0
`define SRW_KIND_NOISE     2'h1
`define SRW_KIND_PDOWN     2'h2
`define SRW_KIND_STANDBY   2'h3

// ========
// peripheral_clock_gate fields
`define SRW_GATE_WIDE      3
`define SRW_GATE_NARROW    2
`define SRW_GATE_SERIAL    1
`define SRW_GATE_CONV      0
`define SRW_GATE_RESET     4'h0

// ========
// watchdog control fields
`define SRW_WD_FLAG        7
`define SRW_WD_IE          6
`define SRW_WD_PS3         5
`define SRW_WD_UNLOCK      4
`define SRW_WD_ON          3
`define SRW_WD_PS_HI       2
`define SRW_WD_PS_LO       0
`define SRW_WD_PS_MAX      4'h9
`define SRW_WD_PS_RESET    4'h0
`define SRW_WD_WINDOW      3'h4

// ========
// reset flag fields
`define SRW_FLG_WDOG       3
`define SRW_FLG_BROWN      2
`define SRW_FLG_EXT        1
`define SRW_FLG_POWER      0

// ========
// bus responses
`define SRW_RESP_OKAY      2'h0
`define SRW_RESP_DECERR    2'h3

// ========
// clocks and watchdog periods
`define SRW_CLK_HZ         200000000
`define SRW_WD_OSC_HZ      128000
`define SRW_WD_BASE        20'h0_0800
`define SRW_STRETCH_W      16

`endif

// *** srw_sleep_reset_wdog.v ***
// sleep, clock gating, reset merge and watchdog control with AXI4-Lite
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "srw_map.vh"

// Behaviour
// [R01] sleep only while sleep_allow_bit is set
// [R02] software sets allow just before sleep, clears on wake
// [R03] kind: 00 idle, 01 noise, 10 power-down, 11 standby
// [R04] standby only with a crystal clock
// [R05] gate bits 7..4 read zero
// [R06] gate bit 3 freezes the wide timer
// [R07] gate bit 2 freezes the narrow timer
// [R08] gate bit 1 stops serial clock; software reinitialises
// [R09] gate bit 0 shuts converter and comparator mux use
// [R10] any reset restores registers; fetch from vector
// [R11] ports reset at once, with no clock
// [R12] a counter stretches reset after all sources release
// [R13] reset merges power-on, pin, watchdog, brown-out
// [R14] pin low resets unclocked; release starts counter
// [R15] brown-out resets at once; recovery waits for counter
// [R16] expiry gives a one-cycle pulse, then the counter
// [R17] bandgap on for brown-out, comparator select, converter
// [R18] watchdog ticks from a 128 kHz oscillator
// [R19] watchdog clears on kick, disable and reset
// [R20] ten periods; unkicked expiry resets
// [R21] interrupt instead of reset, waking power-down
// [R22] level 1 timed disable, level 2 always on
// [R23] change accepted within four cycles of unlock
// [R24] watchdog flag set by its reset, cleared by write 0
// [R25] gated peripherals freeze, registers inaccessible
// [R26] stretch length is a static input in clock cycles
module srw_sleep_reset_wdog (
  // clock and power-on reset
  input  wire        clock,
  input  wire        reset_n,
  // reset sources and fuses
  input  wire        ext_pin_n,
  input  wire        ext_pin_enable,
  input  wire        brownout_low,
  input  wire        brownout_enable,
  input  wire        watchdog_lock_fuse,
  input  wire [15:0] stretch_len,
  // core events and analog selects
  input  wire        sleep_instr,
  input  wire        kick_instr,
  input  wire        wake_event,
  input  wire        comparator_bandgap_select,
  input  wire        converter_enable,
  // AXI4-Lite write
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // resets out
  output reg         core_reset_reg,
  output reg         io_reset_n_reg,
  // clocks and power out
  output reg         sleeping_reg,
  output reg  [1:0]  sleep_kind_reg,
  output reg         cpu_clk_run_reg,
  output reg         io_clk_run_reg,
  output reg         timer_wide_run_reg,
  output reg         timer_narrow_run_reg,
  output reg         serial_clk_run_reg,
  output reg         converter_power_reg,
  output reg         comp_mux_allow_reg,
  output reg         bandgap_on_reg,
  output reg         wd_irq_reg
);
  // ========
  // reset merge
  wire hard_rst_n = reset_n & ~(ext_pin_enable & ~ext_pin_n)
                    & ~(brownout_enable & brownout_low);  // [R13]
  wire hold;
  reg  wd_pulse_reg;

  // pin and brown-out act with no clock, the pulse restarts the delay
  srw_stretch u_stretch (
    .clock      (clock),
    .hard_rst_n (hard_rst_n),       // [R14] [R15]
    .restart    (wd_pulse_reg),     // [R16]
    .len        (stretch_len),      // [R26]
    .hold_reg   (hold)
  );

  // ports go to reset state the instant power-on, pin or brown-out asserts; a watchdog pulse takes one clock edge
  always @(posedge clock or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      io_reset_n_reg <= 1'b0;       // [R11]
      core_reset_reg <= 1'b1;
    end else begin
      io_reset_n_reg <= ~hold & ~wd_pulse_reg;
      core_reset_reg <= hold | wd_pulse_reg;  // [R10]
    end
  end

  // ========
  // registers
  reg  [7:0] spc_reg;
  reg  [3:0] pcg_reg;
  reg        wd_on_reg;
  reg        wd_ie_reg;
  reg        wd_flag_reg;
  reg  [3:0] wd_ps_reg;
  reg  [2:0] unl_cnt_reg;
  reg  [3:0] rst_flags_reg;
  wire       level2 = watchdog_lock_fuse;
  wire       wd_on_eff = level2 | wd_on_reg
                         | rst_flags_reg[`SRW_FLG_WDOG];
  wire       unlocked = (unl_cnt_reg != 3'h0);

  // ========
  // bus write channel
  reg        aw_got_reg;
  reg        w_got_reg;
  reg  [7:0] aw_addr_reg;
  reg  [7:0] w_byte_reg;
  reg        w_en_reg;
  wire       wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire [7:0] wb = w_byte_reg;
  wire       wr_slp = wr_fire & w_en_reg
                      & (aw_addr_reg == `SRW_ADDR_SLEEP);
  wire       wr_gate = wr_fire & w_en_reg
                       & (aw_addr_reg == `SRW_ADDR_GATE);
  wire       wr_wd = wr_fire & w_en_reg
                     & (aw_addr_reg == `SRW_ADDR_WDOG);
  wire       wr_flg = wr_fire & w_en_reg
                      & (aw_addr_reg == `SRW_ADDR_FLAGS);
  wire       addr_ok = (aw_addr_reg == `SRW_ADDR_SLEEP)
                       | (aw_addr_reg == `SRW_ADDR_GATE)
                       | (aw_addr_reg == `SRW_ADDR_WDOG)
                       | (aw_addr_reg == `SRW_ADDR_FLAGS)
                       | (aw_addr_reg == `SRW_ADDR_STATUS);

  // address and data are taken in either order, response after both
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SRW_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_byte_reg    <= 8'h00;
      w_en_reg      <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_reg    <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_reg    <= 1'b1;
        w_byte_reg   <= s_axi_wdata[7:0];
        w_en_reg     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok ? `SRW_RESP_OKAY : `SRW_RESP_DECERR;
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ========
  // sleep and gate registers, reset by every source
  always @(posedge clock or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      spc_reg <= `SRW_SLP_RESET;
      pcg_reg <= `SRW_GATE_RESET;
    end else if (hold) begin
      spc_reg <= `SRW_SLP_RESET;  // [R10]
      pcg_reg <= `SRW_GATE_RESET;
    end else begin
      if (wr_slp)
        spc_reg <= wb & `SRW_SLP_RMASK;
      if (wr_gate)
        pcg_reg <= wb[3:0];        // [R05]
    end
  end

  // ========
  // watchdog oscillator tick; divide rounds down so periods never stretch
  localparam integer DIV_N = `SRW_CLK_HZ / `SRW_WD_OSC_HZ;
  localparam [31:0]  DIV_LAST = DIV_N - 1;
  reg  [10:0] div_reg;
  reg         tick_reg;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_reg  <= 11'h000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == DIV_LAST[10:0]);
      if (div_reg == DIV_LAST[10:0])
        div_reg <= 11'h000;        // [R18]
      else
        div_reg <= div_reg + 11'h001;
    end
  end

  wire wd_run = wd_on_eff | wd_ie_reg;
  wire wd_expire;
  wire [3:0] ps_sel = (wd_ps_reg > `SRW_WD_PS_MAX) ? `SRW_WD_PS_MAX
                                                    : wd_ps_reg;

  srw_wdog_count u_wdog (
    .clock      (clock),
    .reset_n    (reset_n),
    .clear      (kick_instr | ~wd_run | hold),  // [R19]
    .tick       (tick_reg),
    .sel        (ps_sel),                       // [R20]
    .expire_reg (wd_expire)
  );

  // ========
  // watchdog control; unlock write opens a four-cycle window
  wire unl_write = wr_wd & wb[`SRW_WD_UNLOCK] & wb[`SRW_WD_ON];
  wire [3:0] ps_new = {wb[`SRW_WD_PS3], wb[`SRW_WD_PS_HI:`SRW_WD_PS_LO]};
  wire cfg_write = wr_wd & ~wb[`SRW_WD_UNLOCK];
  wire to_irq = wd_expire & wd_ie_reg;
  wire to_rst = wd_expire & ~wd_ie_reg & wd_on_eff;

  always @(posedge clock or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      wd_on_reg    <= 1'b0;
      wd_ie_reg    <= 1'b0;
      wd_flag_reg  <= 1'b0;
      wd_ps_reg    <= `SRW_WD_PS_RESET;
      unl_cnt_reg  <= 3'h0;
      wd_pulse_reg <= 1'b0;
    end else if (hold) begin
      wd_on_reg    <= 1'b0;        // [R22]
      wd_ie_reg    <= 1'b0;
      wd_flag_reg  <= 1'b0;
      wd_ps_reg    <= `SRW_WD_PS_RESET;
      unl_cnt_reg  <= 3'h0;
      wd_pulse_reg <= 1'b0;
    end else begin
      wd_pulse_reg <= to_rst;      // [R16] [R20]
      if (unl_write)
        unl_cnt_reg <= `SRW_WD_WINDOW;  // [R23]
      else if (unlocked)
        unl_cnt_reg <= unl_cnt_reg - 3'h1;
      if (wr_wd) begin
        wd_ie_reg <= wb[`SRW_WD_IE];
        if (wb[`SRW_WD_ON])
          wd_on_reg <= 1'b1;
        else if (cfg_write & unlocked & ~level2)
          wd_on_reg <= 1'b0;       // [R22] [R23]
        if (cfg_write & (unlocked | ~level2))
          wd_ps_reg <= ps_new;     // [R22] [R23]
      end
      // set beats a same-cycle write-one clear
      if (to_irq)
        wd_flag_reg <= 1'b1;       // [R21]
      else if (wr_wd & wb[`SRW_WD_FLAG])
        wd_flag_reg <= 1'b0;
      if (to_irq & wd_on_eff)
        wd_ie_reg <= 1'b0;         // next expiry resets
    end
  end

  // ========
  // reset cause flags survive everything except power-on
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_flags_reg <= 4'h1;
    end else begin
      if (wd_pulse_reg)
        rst_flags_reg[`SRW_FLG_WDOG] <= 1'b1;  // [R24]
      else if (wr_flg & ~wb[`SRW_FLG_WDOG])
        rst_flags_reg[`SRW_FLG_WDOG] <= 1'b0;
      if (brownout_enable & brownout_low)
        rst_flags_reg[`SRW_FLG_BROWN] <= 1'b1;
      else if (wr_flg & ~wb[`SRW_FLG_BROWN])
        rst_flags_reg[`SRW_FLG_BROWN] <= 1'b0;
      if (ext_pin_enable & ~ext_pin_n)
        rst_flags_reg[`SRW_FLG_EXT] <= 1'b1;
      else if (wr_flg & ~wb[`SRW_FLG_EXT])
        rst_flags_reg[`SRW_FLG_EXT] <= 1'b0;
      if (wr_flg & ~wb[`SRW_FLG_POWER])
        rst_flags_reg[`SRW_FLG_POWER] <= 1'b0;
    end
  end

  // ========
  // sleep state; wake on event, watchdog interrupt or reset
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_WAKE  = 3'b100;
  reg [2:0] st_reg;

  always @(posedge clock or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      st_reg         <= ST_RUN;
      sleep_kind_reg <= `SRW_KIND_IDLE;
    end else if (hold) begin
      st_reg <= ST_RUN;
    end else begin
      case (st_reg)
        ST_RUN: begin
          if (sleep_instr & spc_reg[`SRW_SLP_ALLOW]) begin  // [R01]
            st_reg         <= ST_SLEEP;
            sleep_kind_reg <= spc_reg[`SRW_SLP_KIND_HI:`SRW_SLP_KIND_LO];
          end
        end
        ST_SLEEP: begin
          if (wake_event | to_irq)   // [R21]
            st_reg <= ST_WAKE;
        end
        ST_WAKE:
          st_reg <= ST_RUN;
        default:
          st_reg <= ST_RUN;
      endcase
    end
  end

  // ========
  // clock and power outputs, all registered
  wire asleep = (st_reg == ST_SLEEP);
  wire io_kind = (sleep_kind_reg == `SRW_KIND_IDLE);  // [R03]
  always @(posedge clock or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      sleeping_reg         <= 1'b0;
      cpu_clk_run_reg      <= 1'b0;
      io_clk_run_reg       <= 1'b0;
      timer_wide_run_reg   <= 1'b0;
      timer_narrow_run_reg <= 1'b0;
      serial_clk_run_reg   <= 1'b0;
      converter_power_reg  <= 1'b0;
      comp_mux_allow_reg   <= 1'b0;
      bandgap_on_reg       <= 1'b0;
      wd_irq_reg           <= 1'b0;
    end else begin
      sleeping_reg    <= asleep;
      cpu_clk_run_reg <= ~asleep & ~hold;
      io_clk_run_reg  <= ~hold & (~asleep | io_kind);
      // gating clears the run enables to freeze state; register access is not blocked here
      timer_wide_run_reg   <= ~pcg_reg[`SRW_GATE_WIDE];     // [R06] [R25]
      timer_narrow_run_reg <= ~pcg_reg[`SRW_GATE_NARROW];   // [R07] [R25]
      serial_clk_run_reg   <= ~pcg_reg[`SRW_GATE_SERIAL];   // [R08] [R25]
      converter_power_reg  <= ~pcg_reg[`SRW_GATE_CONV]
                              & converter_enable;           // [R09]
      comp_mux_allow_reg   <= ~pcg_reg[`SRW_GATE_CONV];     // [R09]
      bandgap_on_reg <= brownout_enable | comparator_bandgap_select
                        | converter_enable;                 // [R17]
      wd_irq_reg <= wd_flag_reg & wd_ie_reg;                // [R21]
    end
  end

  // ========
  // bus read channel, data one cycle after the address is taken
  reg [7:0] rd_byte;
  reg       rd_ok;
  always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `SRW_ADDR_SLEEP:  rd_byte = spc_reg;
      `SRW_ADDR_GATE:   rd_byte = {4'h0, pcg_reg};  // [R05]
      `SRW_ADDR_WDOG:   rd_byte = {wd_flag_reg, wd_ie_reg, wd_ps_reg[3],
                                   unlocked, wd_on_eff, wd_ps_reg[2:0]};
      `SRW_ADDR_FLAGS:  rd_byte = {4'h0, rst_flags_reg};
      `SRW_ADDR_STATUS: rd_byte = {5'h00, st_reg};
      default:          rd_ok   = 1'b0;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SRW_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_ok ? `SRW_RESP_OKAY : `SRW_RESP_DECERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// *** srw_sleep_reset_wdog_asserts.sv ***
// concurrent checks on the sleep, reset and watchdog control block
`timescale 1ns/1ps
module srw_sleep_reset_wdog_asserts (
  // clock and power-on reset
  input wire        clock,
  input wire        reset_n,
  // reset sources and static length
  input wire        ext_pin_n,
  input wire        ext_pin_enable,
  input wire        brownout_low,
  input wire        brownout_enable,
  input wire [15:0] stretch_len,
  // core events and analog selects
  input wire        sleep_instr,
  input wire        comparator_bandgap_select,
  input wire        converter_enable,
  // read channel
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // block outputs
  input wire        core_reset_reg,
  input wire        io_reset_n_reg,
  input wire        sleeping_reg,
  input wire [1:0]  sleep_kind_reg,
  input wire        cpu_clk_run_reg,
  input wire        io_clk_run_reg,
  input wire        converter_power_reg,
  input wire        comp_mux_allow_reg,
  input wire        bandgap_on_reg
);
  // ========
  // helper: edges counted since the hard sources let go
  wire       hard = (ext_pin_enable & ~ext_pin_n) |
                    (brownout_enable & brownout_low);
  wire       bg_src = brownout_enable | comparator_bandgap_select |
                      converter_enable;
  reg [16:0] rel_cnt;

  // zero while running, so a watchdog hold starts a fresh count
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      rel_cnt <= 17'h0_0000;
    else if (hard || !core_reset_reg)
      rel_cnt <= 17'h0_0000;
    else
      rel_cnt <= rel_cnt + 17'h0_0001;
  end

  // ========
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence r_stall; s_axi_rvalid && !s_axi_rready; endsequence
  sequence sleep_entry; $rose(sleeping_reg) ##1 sleeping_reg; endsequence

  chk_io_pin_async: assert property (hard |->
    !io_reset_n_reg && core_reset_reg) else $error("ports not in reset");
  chk_stretch_min: assert property ($fell(core_reset_reg) |->
    rel_cnt >= stretch_len + 1) else $error("reset stretch too short");
  chk_stretch_max: assert property (core_reset_reg && !hard |->
    rel_cnt <= stretch_len + 4) else $error("reset stretch too long");
  chk_sleep_cause: assert property ($rose(sleeping_reg) |->
    $past(sleep_instr) || $past(sleep_instr, 2))
    else $error("sleep without instruction");
  chk_sleep_clocks: assert property (sleep_entry |-> !cpu_clk_run_reg &&
    io_clk_run_reg == (sleep_kind_reg == 2'h0))
    else $error("clock enables wrong in sleep");
  chk_bandgap_srcs: assert property (!core_reset_reg &&
    !$past(core_reset_reg) |-> bandgap_on_reg == $past(bg_src))
    else $error("bandgap enable wrong");
  chk_conv_mux: assert property (converter_power_reg |->
    comp_mux_allow_reg && $past(converter_enable))
    else $error("converter powered while shut down");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (r_stall |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind srw_sleep_reset_wdog srw_sleep_reset_wdog_asserts i_chk (.*);

// *** srw_sleep_reset_wdog_tb.sv ***
// self-checking bench for the sleep, reset and watchdog control block
`timescale 1ns/1ps
`include "srw_map.vh"
`define CHK(n, e, g) begin n_compared = n_compared + 1; \
  if ((g) !== (e)) begin miscompares = miscompares + 1; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module srw_sleep_reset_wdog_tb;
  // ========
  // design signals, named as its ports
  reg  clock = 1'b0, reset_n = 1'b0, ext_pin_n = 1'b1, ext_pin_enable = 1'b1;
  reg  brownout_low = 1'b0, brownout_enable = 1'b0, watchdog_lock_fuse = 1'b0;
  reg  comparator_bandgap_select = 1'b0, converter_enable = 1'b0;
  reg  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg  [15:0] stretch_len = 16'h0014;
  reg  req_sleep = 1'b0, req_kick = 1'b0, req_wake = 1'b0;
  wire sleep_instr, kick_instr, wake_event, s_axi_awready, s_axi_wready;
  wire s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_reset_reg;
  wire io_reset_n_reg, sleeping_reg, cpu_clk_run_reg, io_clk_run_reg;
  wire timer_wide_run_reg, timer_narrow_run_reg, serial_clk_run_reg;
  wire converter_power_reg, comp_mux_allow_reg, bandgap_on_reg, wd_irq_reg;
  wire [1:0]  s_axi_bresp, s_axi_rresp, sleep_kind_reg;
  wire [31:0] s_axi_rdata;
  // bench state
  integer     miscompares = 0, n_compared = 0, cyc = 0, i, k, n, seed = 97;
  reg [7:0]   d, g, flg;
  reg [31:0]  rd;
  reg [1:0]   resp;

  srw_sleep_reset_wdog i_srw_sleep_reset_wdog (.*);
  srw_core_model i_srw_core_model (.*);

  // ========
  // clock and hang guard
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end

  // ========
  // bus tasks: hold each channel until taken
  task axi_wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] a);
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task chk_rd(input [7:0] a, input [7:0] e);
    begin
      axi_rd(a);
      `CHK("register", {24'h00_0000, e}, rd)
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // ========
  // main sequence; expectations come from a small shadow model
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    while (core_reset_reg !== 1'b0) @(posedge clock);
    flg = 8'h01;
    chk_rd(`SRW_ADDR_FLAGS, flg);
    // random register traffic and the gated outputs
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      g = $random(seed);
      converter_enable <= ~g[0] & d[0];
      axi_wr(`SRW_ADDR_SLEEP, d);
      axi_wr(`SRW_ADDR_GATE, g);
      chk_rd(`SRW_ADDR_SLEEP, d & 8'hFB);
      chk_rd(`SRW_ADDR_GATE, g & 8'h0F);
      `CHK("wide", ~g[3], timer_wide_run_reg)
      `CHK("narrow", ~g[2], timer_narrow_run_reg)
      `CHK("serial", ~g[1], serial_clk_run_reg)
      `CHK("conv", ~g[0] & d[0], converter_power_reg)
      `CHK("mux", ~g[0], comp_mux_allow_reg)
      `CHK("irq", 1'b0, wd_irq_reg)
    end
    axi_wr(`SRW_ADDR_GATE, 8'h00);
    axi_wr(8'h20, 8'hFF);
    `CHK("wr_resp", `SRW_RESP_DECERR, resp)
    axi_rd(8'h20);
    `CHK("rd_resp", `SRW_RESP_DECERR, resp)
    // every sleep kind, then a sleep instruction with allow clear
    for (k = 0; k < 5; k = k + 1) begin
      axi_wr(`SRW_ADDR_SLEEP, {2'b00, k < 4, k[1:0], 3'b000});
      req_sleep <= 1'b1;
      @(posedge clock) req_sleep <= 1'b0;
      repeat (4) @(posedge clock);
      `CHK("asleep", k < 4, sleeping_reg)
      if (k < 4) begin
        `CHK("kind", k[1:0], sleep_kind_reg)
        `CHK("cpu_clk", 1'b0, cpu_clk_run_reg)
        `CHK("io_clk", k == 0, io_clk_run_reg)
        req_wake <= 1'b1;
        @(posedge clock) req_wake <= 1'b0;
        while (sleeping_reg !== 1'b0) @(posedge clock);
        axi_wr(`SRW_ADDR_SLEEP, 8'h00);
      end
    end
    // all eight combinations of the reference users
    for (i = 0; i < 8; i = i + 1) begin
      brownout_enable <= i[0];
      comparator_bandgap_select <= i[1];
      converter_enable <= i[2];
      repeat (3) @(posedge clock);
      `CHK("bandgap", |i[2:0], bandgap_on_reg)
    end
    // watchdog starts off at level 1; clearing needs the unlock
    axi_rd(`SRW_ADDR_WDOG);
    `CHK("wd_init", 1'b0, rd[3])
    axi_wr(`SRW_ADDR_WDOG, 8'h08);
    req_kick <= 1'b1;
    @(posedge clock) req_kick <= 1'b0;
    axi_wr(`SRW_ADDR_WDOG, 8'h00);
    axi_rd(`SRW_ADDR_WDOG);
    `CHK("wd_locked", 1'b1, rd[3])
    axi_wr(`SRW_ADDR_WDOG, 8'h18);
    axi_wr(`SRW_ADDR_WDOG, 8'h00);
    axi_rd(`SRW_ADDR_WDOG);
    `CHK("wd_unlock", 1'b0, rd[3])
    // pin then brown-out, asserted between clock edges
    axi_wr(`SRW_ADDR_SLEEP, 8'h20);
    for (k = 0; k < 2; k = k + 1) begin
      #2;
      if (k == 0) ext_pin_n = 1'b0;
      else brownout_low = 1'b1;
      #1;
      `CHK("io_rst", 1'b0, io_reset_n_reg)
      `CHK("core_rst", 1'b1, core_reset_reg)
      repeat (3) @(posedge clock);
      ext_pin_n <= 1'b1;
      brownout_low <= 1'b0;
      n = 0;
      while (core_reset_reg !== 1'b0) begin
        @(posedge clock);
        n = n + 1;
      end
      `CHK("stretch", 1'b1, n >= 21 && n <= 24)
      flg = flg | (k == 0 ? 8'h02 : 8'h04);
      chk_rd(`SRW_ADDR_FLAGS, flg);
      chk_rd(`SRW_ADDR_SLEEP, 8'h00);
      axi_rd(`SRW_ADDR_WDOG);
      `CHK("wd_off", 1'b0, rd[3])
    end
    axi_wr(`SRW_ADDR_FLAGS, 8'h00);
    chk_rd(`SRW_ADDR_FLAGS, 8'h00);
    complete_run;
  end
endmodule

// *** srw_stretch.v ***
// reset stretch delay counter
`timescale 1ns/1ps
`include "srw_map.vh"
module srw_stretch (
  // clock and hard reset
  input  wire                      clock,
  input  wire                      hard_rst_n,
  // control
  input  wire                      restart,
  input  wire [`SRW_STRETCH_W-1:0] len,
  // stretched reset, high while the core is held
  output reg                       hold_reg
);
  reg [`SRW_STRETCH_W-1:0] cnt_reg;

  // counting starts the cycle after the last source releases
  always @(posedge clock or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      cnt_reg  <= {`SRW_STRETCH_W{1'b0}};
      hold_reg <= 1'b1;
    end else if (restart) begin
      cnt_reg  <= {`SRW_STRETCH_W{1'b0}};
      hold_reg <= 1'b1;
    end else if (hold_reg) begin
      if (cnt_reg == len)
        hold_reg <= 1'b0;   // [R12]
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// *** srw_wdog_count.v ***
// watchdog period counter on the oscillator tick
`timescale 1ns/1ps
`include "srw_map.vh"
module srw_wdog_count (
  // clock and reset
  input  wire       clock,
  input  wire       reset_n,
  // control
  input  wire       clear,
  input  wire       tick,
  input  wire [3:0] sel,
  // one-cycle expiry
  output reg        expire_reg
);
  reg  [19:0] cnt_reg;
  wire [19:0] last = (`SRW_WD_BASE << sel) - 20'h0_0001;

  // ten periods of 2K to 1024K oscillator cycles
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg    <= 20'h0_0000;
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= 1'b0;
      if (clear)
        cnt_reg <= 20'h0_0000;   // [R19]
      else if (tick) begin
        if (cnt_reg >= last) begin
          cnt_reg    <= 20'h0_0000;
          expire_reg <= 1'b1;    // [R20]
        end else
          cnt_reg <= cnt_reg + 20'h0_0001;
      end
    end
  end
endmodule
